// ### design/hw_xfer.v
// Purpose: Halfword and signed data transfer execution sequencer
// Assumes: Register file outside; operands arrive with the start pulse
// Notes:   Condition pass is evaluated outside and given as cond_pass_i
`timescale 1ns/100ps
`default_nettype none
`include "hw_xfer_consts.vh"
module hw_xfer (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Instruction issue
  input  wire        start_i,
  input  wire [31:0] instr_i,
  input  wire        cond_pass_i,
  input  wire [31:0] instr_addr_i,
  input  wire [31:0] base_val_i,
  input  wire [31:0] offset_val_i,
  input  wire [31:0] src_val_i,
  // Memory side
  input  wire [31:0] mem_rdata_i,
  input  wire        abort_i,
  input  wire        endian_select_i,
  output reg  [31:0] mem_addr_o,
  output reg  [31:0] mem_wdata_o,
  output reg         mem_req_o,
  output reg         mem_write_o,
  output reg         mem_seq_o,
  output reg         mem_half_o,
  // Register writes
  output reg         dst_we_o,
  output reg  [3:0]  dst_idx_o,
  output reg  [31:0] dst_val_o,
  output reg         base_we_o,
  output reg  [3:0]  base_idx_o,
  output reg  [31:0] base_val_o,
  // Status
  output reg         busy_o,
  output reg         done_o,
  output reg         data_abort_o
);
  ////////////////////////////////////////////////////////////////////
  localparam S_IDLE  = 3'h0;
  localparam S_ADDR  = 3'h1;
  localparam S_DATA  = 3'h2;
  localparam S_INT   = 3'h3;
  localparam S_PC1   = 3'h4;
  localparam S_PC2   = 3'h5;
  localparam S_STORE = 3'h6;

  // Abort is from the memory manager, treated as same-clock logic
  function [31:0] apply_offset;
    input [31:0] base;
    input [31:0] offs;
    input        up;
    begin
      apply_offset = up ? base + offs : base - offs;
    end
  endfunction

  reg  [2:0]  state;
  reg  [31:0] ir;
  reg  [31:0] base_eff;
  reg  [31:0] offs_eff;
  reg  [31:0] store_src;
  reg  [31:0] load_val;
  reg         aborted;
  wire [31:0] ext_val;
  wire [31:0] start_base;
  wire [31:0] start_offs;
  wire [31:0] new_base;
  wire [31:0] xfer_addr;
  wire        is_load;
  wire        wants_wb;
  wire        to_pc;

  assign start_base = (instr_i[`F_BASE_HI:`F_BASE_LO] == `PC_INDEX) ?
                      instr_addr_i + `PC_BASE_ADJ : base_val_i;
  assign start_offs = instr_i[`F_IMM] ?
                      {24'h000000, instr_i[`F_IMMH_HI:`F_IMMH_LO],
                       instr_i[`F_OFFS_HI:`F_OFFS_LO]} : offset_val_i;
  assign new_base  = apply_offset(base_eff, offs_eff, ir[`F_UP]);
  assign xfer_addr = ir[`F_PRE] ? new_base : base_eff;
  assign is_load   = ir[`F_LOAD];
  // Post-indexed always writes back; pre only with writeback bit
  assign wants_wb  = !ir[`F_PRE] | ir[`F_WB];
  assign to_pc     = ir[`F_DST_HI:`F_DST_LO] == `PC_INDEX;

  hw_extend u_ext (
    .bus_i           (mem_rdata_i),
    .addr_i          (mem_addr_o[1:0]),
    .endian_select_i (endian_select_i),
    .sign_i          (ir[`F_SIGN]),
    .half_i          (ir[`F_HALF]),
    .value_o         (ext_val)
  );

  ////////////////////////////////////////////////////////////////////
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state        <= S_IDLE;
      ir           <= `DATA_RESET;
      base_eff     <= `DATA_RESET;
      offs_eff     <= `DATA_RESET;
      store_src    <= `DATA_RESET;
      load_val     <= `DATA_RESET;
      aborted      <= 1'b0;
      mem_addr_o   <= `DATA_RESET;
      mem_wdata_o  <= `DATA_RESET;
      mem_req_o    <= 1'b0;
      mem_write_o  <= 1'b0;
      mem_seq_o    <= 1'b0;
      mem_half_o   <= 1'b0;
      dst_we_o     <= 1'b0;
      dst_idx_o    <= 4'h0;
      dst_val_o    <= `DATA_RESET;
      base_we_o    <= 1'b0;
      base_idx_o   <= 4'h0;
      base_val_o   <= `DATA_RESET;
      busy_o       <= 1'b0;
      done_o       <= 1'b0;
      data_abort_o <= 1'b0;
    end else begin
      dst_we_o     <= 1'b0;
      base_we_o    <= 1'b0;
      done_o       <= 1'b0;
      data_abort_o <= 1'b0;
      case (state)
        S_IDLE: begin
          mem_req_o <= 1'b0;
          if (start_i) begin
            if (cond_pass_i) begin
              ir        <= instr_i;
              base_eff  <= start_base;
              offs_eff  <= start_offs;
              store_src <= (instr_i[`F_DST_HI:`F_DST_LO] == `PC_INDEX) ?
                           instr_addr_i + `PC_STORE_ADJ : src_val_i;
              aborted   <= 1'b0;
              busy_o    <= 1'b1;
              state     <= S_ADDR;
            end else begin
              done_o <= 1'b1;
            end
          end
        end
        S_ADDR: begin
          // First cycle: address computation, non-sequential access issued
          mem_addr_o  <= xfer_addr;
          mem_req_o   <= 1'b1;
          mem_seq_o   <= 1'b0;
          mem_half_o  <= ir[`F_HALF];
          // Signed store is illegal; treated as load to stay safe
          mem_write_o <= !is_load && !ir[`F_SIGN];
          mem_wdata_o <= {store_src[15:0], store_src[15:0]};
          // Base update lands in the first cycle, as the abort handler expects
          if (wants_wb) begin
            base_we_o  <= 1'b1;
            base_idx_o <= ir[`F_BASE_HI:`F_BASE_LO];
            base_val_o <= new_base;
          end
          state <= (!is_load && !ir[`F_SIGN]) ? S_STORE : S_DATA;
        end
        S_STORE: begin
          // Second N cycle: data driven, abort sampled
          mem_req_o   <= 1'b0;
          mem_write_o <= 1'b0;
          if (abort_i)
            data_abort_o <= 1'b1;
          done_o <= 1'b1;
          busy_o <= 1'b0;
          state  <= S_IDLE;
        end
        S_DATA: begin
          // Data cycle; odd halfword addresses give lane garbage
          mem_req_o   <= 1'b0;
          mem_write_o <= 1'b0;
          load_val    <= ext_val;
          aborted     <= abort_i;
          state       <= S_INT;
        end
        S_INT: begin
          // Internal cycle writes the destination unless aborted
          if (aborted) begin
            data_abort_o <= 1'b1;
            done_o       <= 1'b1;
            busy_o       <= 1'b0;
            state        <= S_IDLE;
          end else begin
            dst_we_o  <= 1'b1;
            dst_idx_o <= ir[`F_DST_HI:`F_DST_LO];
            dst_val_o <= load_val;
            if (to_pc) begin
              // Refill: N then S fetches at the new target
              mem_addr_o <= load_val;
              mem_req_o  <= 1'b1;
              mem_seq_o  <= 1'b0;
              state      <= S_PC1;
            end else begin
              done_o <= 1'b1;
              busy_o <= 1'b0;
              state  <= S_IDLE;
            end
          end
        end
        S_PC1: begin
          mem_addr_o <= mem_addr_o + 32'h00000004;
          mem_seq_o  <= 1'b1;
          state      <= S_PC2;
        end
        default: begin
          mem_req_o <= 1'b0;
          mem_seq_o <= 1'b0;
          done_o    <= 1'b1;
          busy_o    <= 1'b0;
          state     <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### design/hw_xfer_consts.vh
// Purpose: Constants for the halfword and signed transfer unit
// Assumes: 32-bit instruction and data words
// Notes:   Field positions follow the instruction encoding
`ifndef HW_XFER_CONSTS_VH
`define HW_XFER_CONSTS_VH
`define F_COND_HI      31
`define F_COND_LO      28
`define F_PRE          24
`define F_UP           23
`define F_IMM          22
`define F_WB           21
`define F_LOAD         20
`define F_BASE_HI      19
`define F_BASE_LO      16
`define F_DST_HI       15
`define F_DST_LO       12
`define F_IMMH_HI      11
`define F_IMMH_LO      8
`define F_SIGN         6
`define F_HALF         5
`define F_OFFS_HI      3
`define F_OFFS_LO      0
`define PC_INDEX       4'hF
`define PC_BASE_ADJ    32'h00000008
`define PC_STORE_ADJ   32'h0000000C
`define DATA_RESET     32'h00000000
`endif

// ### design/hw_extend.v
// Purpose: Lane select and zero or sign extension of loaded data
// Assumes: Combinational, used by the transfer sequencer
// Notes:   Odd halfword addresses give whatever lanes fall out
`timescale 1ns/100ps
`default_nettype none
module hw_extend (
  // Data and address
  input  wire [31:0] bus_i,
  input  wire [1:0]  addr_i,
  // Mode
  input  wire        endian_select_i,
  input  wire        sign_i,
  input  wire        half_i,
  // Result
  output reg  [31:0] value_o
);
  reg [7:0]  byte_sel;
  reg [15:0] half_sel;
  always @* begin
    // Big endian mirrors the lane index
    if (endian_select_i) begin
      case (addr_i)
        2'h0: byte_sel = bus_i[31:24];
        2'h1: byte_sel = bus_i[23:16];
        2'h2: byte_sel = bus_i[15:8];
        default: byte_sel = bus_i[7:0];
      endcase
      half_sel = addr_i[1] ? bus_i[15:0] : bus_i[31:16];
    end else begin
      case (addr_i)
        2'h0: byte_sel = bus_i[7:0];
        2'h1: byte_sel = bus_i[15:8];
        2'h2: byte_sel = bus_i[23:16];
        default: byte_sel = bus_i[31:24];
      endcase
      half_sel = addr_i[1] ? bus_i[31:16] : bus_i[15:0];
    end
    if (!half_i)
      value_o = {{24{byte_sel[7]}}, byte_sel};
    else if (sign_i)
      value_o = {{16{half_sel[15]}}, half_sel};
    else
      value_o = {16'h0000, half_sel};
  end
endmodule
`default_nettype wire

// ### verif/mem_model.sv
// Purpose: Far-side memory and manager model
// Assumes: Read data is only valid while a read is requested
// Notes:   Idle bus toggles so stale data cannot pass
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic        write_i,
  input  wire logic        busy_i,
  input  wire logic [31:0] word_i,
  input  wire logic        abort_en_i,
  output logic      [31:0] rdata_o,
  output logic             abort_o
);
  logic [31:0] last = 32'h0000_0000;
  always_ff @(posedge clk_i) last <= ~rdata_o;
  assign rdata_o = (req_i && !write_i) ? word_i : last;
  // Manager flags the whole transfer when told to
  assign abort_o = abort_en_i && busy_i;
endmodule
`default_nettype wire

// ### verif/hw_xfer_chk.sv
// Purpose: Port assertions for hw_xfer
// Assumes: One clock, async reset high
// Notes:   Mode bits latched at issue
`timescale 1ns/100ps
`default_nettype none
module hw_xfer_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        start_i,
  input wire logic [31:0] instr_i,
  input wire logic        cond_pass_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        dst_we_o,
  input wire logic [31:0] dst_val_o,
  input wire logic        base_we_o,
  input wire logic        mem_req_o,
  input wire logic        mem_write_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic        data_abort_o
);
  logic [4:0] f;
  logic       go;
  assign go = start_i && !busy_o;
  // Pre, writeback, load, sign, half of the instruction in flight
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) f <= 5'h00;
    else if (go) f <= {instr_i[24], instr_i[21:20], instr_i[6:5]};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_skip; go && !cond_pass_i |=> (!mem_req_o && !dst_we_o && !base_we_o) [*3]; endproperty
  a_skip: assert property (p_skip) else $error("failed condition acted");
  property p_rep; mem_req_o && mem_write_o |-> mem_wdata_o[31:16] == mem_wdata_o[15:0]; endproperty
  a_rep: assert property (p_rep) else $error("store halves differ");
  property p_sb; dst_we_o && f[1:0] == 2'h2 |-> dst_val_o[31:8] == {24{dst_val_o[7]}}; endproperty
  a_sb: assert property (p_sb) else $error("byte sign fill wrong");
  property p_sh; dst_we_o && f[1:0] == 2'h3 |-> dst_val_o[31:16] == {16{dst_val_o[15]}}; endproperty
  a_sh: assert property (p_sh) else $error("half sign fill wrong");
  property p_uh; dst_we_o && f[1:0] == 2'h1 |-> dst_val_o[31:16] == 16'h0000; endproperty
  a_uh: assert property (p_uh) else $error("upper half not cleared");
  property p_wb; base_we_o |-> !f[4] || f[3]; endproperty
  a_wb: assert property (p_wb) else $error("unexpected base write");
  property p_ld; go && cond_pass_i && instr_i[20] |-> ##[3:7] done_o; endproperty
  a_ld: assert property (p_ld) else $error("load too slow");
  property p_st; go && cond_pass_i && !instr_i[20] && !instr_i[6] |-> ##[2:5] done_o; endproperty
  a_st: assert property (p_st) else $error("store too slow");
  property p_ab; data_abort_o |-> done_o && !dst_we_o; endproperty
  a_ab: assert property (p_ab) else $error("abort wrote register");
endmodule
bind hw_xfer hw_xfer_chk u_chk (.clk_i, .rst_i, .start_i, .instr_i, .cond_pass_i, .busy_o,
  .done_o, .dst_we_o, .dst_val_o, .base_we_o, .mem_req_o, .mem_write_o, .mem_wdata_o,
  .data_abort_o);
`default_nettype wire

// ### verif/tb.sv
// Purpose: Self-checking bench for hw_xfer
// Assumes: Memory model answers while a read is requested
// Notes:   Halfword addresses kept even
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
$display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, cond_pass_i = 1'b0;
  logic        endian_select_i = 1'b0, ab = 1'b0, p, w, l, s;
  logic [31:0] instr_i = 32'h0, instr_addr_i = 32'h0, base_val_i = 32'h0;
  logic [31:0] offset_val_i = 32'h0, src_val_i = 32'h0, word = 32'h0, r;
  wire  [31:0] mem_rdata_i, mem_addr_o, mem_wdata_o, dst_val_o, base_val_o;
  wire  [3:0]  dst_idx_o, base_idx_o;
  wire         abort_i, mem_req_o, mem_write_o, mem_seq_o, mem_half_o, dst_we_o;
  wire         base_we_o, busy_o, done_o, data_abort_o;
  int          error_cnt = 0, compares = 0, i, n;
  hw_xfer u_dut (.*);
  mem_model u_mem (.clk_i, .req_i(mem_req_o), .write_i(mem_write_o), .busy_i(busy_o),
    .word_i(word), .abort_en_i(ab), .rdata_o(mem_rdata_i), .abort_o(abort_i));
  always #50 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  function automatic [31:0] mk(input p, u, im, wb, ld, input [3:0] rn, rd, input sg, hf,
                               input [7:0] v);
    mk = {4'hE, 3'h0, p, u, im, wb, ld, rn, rd, v[7:4], 1'b1, sg, hf, 1'b1, v[3:0]};
  endfunction
  task automatic results();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic run(input [31:0] ins, b, o, sr, input c, e, a);
    logic [31:0] pc, bs, os, nb, ea, rw, dt, xp, sv, ad, wd, bv, dv;
    logic        rq, bw, dw, ob, mh;
    logic [3:0]  di, bi;
    int          k, sh;
    pc = $urandom & 32'hFFFF_FFFC;
    rw = $urandom;
    bs = (ins[19:16] == 4'hF) ? pc + 32'h8 : b;
    os = ins[22] ? {24'h0, ins[11:8], ins[3:0]} : o;
    nb = ins[23] ? bs + os : bs - os;
    ea = ins[24] ? nb : bs;
    // Lanes rise with the offset in little endian, fall in big endian
    sh = e ? (ins[5] ? 2 : 3) - ea[1:0] : ea[1:0];
    dt = rw >> (8 * sh);
    xp = ins[5] ? {{16{dt[15] & ins[6]}}, dt[15:0]} : {{24{dt[7]}}, dt[7:0]};
    sv = (ins[15:12] == 4'hF) ? pc + 32'hC : sr;
    @(posedge clk_i);
    {start_i, instr_i, cond_pass_i, instr_addr_i, base_val_i} <= {1'b1, ins, c, pc, b};
    {offset_val_i, src_val_i, endian_select_i, ab, word} <= {o, sr, e, a, rw};
    @(posedge clk_i);
    start_i <= 1'b0;
    {rq, bw, dw, ob, mh} = 5'h00;
    {di, bi} = 8'h00;
    k = 0;
    // First look just after the start edge: a skipped one pulses done there
    do begin
      #1;
      k++;
      if (mem_req_o && !rq) {rq, ad, wd, mh} = {1'b1, mem_addr_o, mem_wdata_o, mem_half_o};
      if (base_we_o) {bw, bv, bi} = {1'b1, base_val_o, base_idx_o};
      if (dst_we_o) {dw, dv, di} = {1'b1, dst_val_o, dst_idx_o};
      ob |= data_abort_o;
      if (!done_o && k < 12) @(posedge clk_i);
    end while (!done_o && k < 12);
    `CHK("done", 1'b1, done_o)
    if (!c) `CHK("skip", 3'h0, {rq, bw, dw})
    else begin
      `CHK("addr", ea, ad)
      `CHK("wb", !ins[24] || ins[21], bw)
      `CHK("base", nb, bw ? bv : nb)
      `CHK("abort", a, ob)
      `CHK("half", ins[5], mh)
      if (bw) `CHK("base_idx", ins[19:16], bi)
      if (ins[20] && !a) `CHK("dst_idx", ins[15:12], di)
      if (ins[20]) `CHK("dst", {!a, xp}, {dw, a ? xp : dv})
      else `CHK("wdata", {sv[15:0], sv[15:0]}, wd)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    error_cnt++;
    results();
  end
  initial begin
    n = $urandom(25);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // Each size, sign, lane and endian mode; halfwords kept aligned
    for (i = 0; i < 24; i++) begin
      s = i < 16;
      w = i >= 8;
      r = $urandom;
      run(mk(1, 1, 1, 0, 1, 4'h1, 4'h2, s, w, 8'h00), {r[31:2], i[2], i[1] & !w},
        32'h0, 32'h0, 1'b1, i[0], 1'b0);
    end
    $display("lane test done");
    // Mixed indexing, program counter base, skipped and aborted transfers
    for (i = 0; i < 48; i++) begin
      r = $urandom;
      p = r[1] | (i % 8 == 6);
      l = r[8];
      s = l & r[9];
      run(mk(p, r[2], r[3], r[4] & p & (i % 8 != 6), l, (i % 8 == 6) ? 4'hF : {1'b0, r[13:11]},
        r[19:16], s, !s | r[10], r[3] ? {r[27:24], r[31:29], 1'b0} : 8'h02),
        $urandom & 32'hFFFF_FFFE, $urandom & 32'hFFFF_FFFE, $urandom, i % 8 != 5, r[5],
        i % 8 == 3);
    end
    $display("mixed test done");
    results();
  end
endmodule
`default_nettype wire
